// ### logic/usb_dma_rx_bufcount_tx_state.sv
// Receive buffer counters and first two transmit DMA state words.
// Assumes a single-cycle register port and DMA strobes synchronous to CLK_SYS.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "usb_dma_state_map.svh"

// Notes on behaviour
// - Four 16-bit receive buffer counters.
// - Software write adds to counter.
// - Word0 bits 31-2 queue head pointer.
// - Word1 bits 31-2 packet first descriptor.
// - Bit0 in-packet flag, bit1 reads zero.
// - Reset zero; counter upper half reads zero.
module usb_dma_rx_bufcount_tx_state (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // Receive DMA buffer consumption, one strobe per channel
    input  wire logic [3:0]  RX_BUF_CONSUME,
    // Transmit DMA packet progress
    input  wire logic        TX_PKT_START,
    input  wire logic [29:0] TX_PKT_SOP_PTR,
    input  wire logic        TX_PKT_END,
    // Per-channel buffer availability and transmit in-packet flag
    output logic [3:0]       RX_BUF_AVAIL,
    output logic             TX_IN_PACKET,
    // Buffer event stream out
    output logic             EVT_VALID,
    input  wire logic        EVT_READY,
    output logic [31:0]      EVT_DATA
);
    typedef struct packed {
        usb_dma_state_pkg::tally_t [3:0] queued_buffer_tally;
        usb_dma_state_pkg::desc_ptr_t    transmit_queue_front_pointer;
        usb_dma_state_pkg::desc_ptr_t    packet_first_descriptor_pointer;
        usb_dma_state_pkg::pkt_state_t   pkt_state;
        usb_dma_state_pkg::word_t        rdata;
        logic [3:0]                      avail;
        logic                            in_pkt_out;
        logic                            evt_valid;
        usb_dma_state_pkg::word_t        evt_data;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic                            evq_in_ready;
    logic                            evq_in_valid;
    usb_dma_state_pkg::word_t        evq_in_data;
    logic                            evq_out_valid;
    logic                            evq_out_ready;
    usb_dma_state_pkg::word_t        evq_out_data;
    logic [4:0]                      evq_level;
    logic [3:0]                      consume_ok;
    logic [3:0]                      add_hit;
    logic                            in_pkt;

    assign in_pkt = (st_r.pkt_state == usb_dma_state_pkg::PKT_BUSY);

    // Buffer events: channel and its tally before the decrement are logged for the drain side.
    // A full queue stalls consumption; when several channels consume at once only the lowest is logged.
    always_comb begin
        evq_in_valid = 1'b0;
        evq_in_data  = '0;
        for (int i = 3; i >= 0; i--) begin
            if (RX_BUF_CONSUME[i]) begin
                evq_in_valid = 1'b1;
                evq_in_data  = {14'h0000, 2'(i), st_r.queued_buffer_tally[i]};
            end
        end
    end

    // Only a counter that holds buffers can be consumed from.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_chan
            assign add_hit[g]    = REG_WR && (REG_ADDR == (`RXBC_OFF_CH0 + 8'(4 * g)));
            assign consume_ok[g] = RX_BUF_CONSUME[g] && evq_in_ready
                                   && (st_r.queued_buffer_tally[g] != 16'h0000);
        end
    endgenerate

    assign evq_out_ready = st_r.evt_valid ? EVT_READY : 1'b1;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.rdata     = '0;
        st_nxt.evt_valid = st_r.evt_valid && !EVT_READY;
        for (int i = 0; i < 4; i++) begin
            st_nxt.queued_buffer_tally[i] = st_r.queued_buffer_tally[i]
                + (add_hit[i] ? REG_WDATA[`RXBC_CNT_MSB:0] : 16'h0000)
                - (consume_ok[i] ? 16'h0001 : 16'h0000);
            st_nxt.avail[i] = (st_nxt.queued_buffer_tally[i] >= 16'h0003);
        end
        case (st_r.pkt_state)
            usb_dma_state_pkg::PKT_IDLE: begin
                if (TX_PKT_START) begin
                    st_nxt.pkt_state                       = usb_dma_state_pkg::PKT_BUSY;
                    st_nxt.packet_first_descriptor_pointer = TX_PKT_SOP_PTR;
                end
            end
            usb_dma_state_pkg::PKT_BUSY: begin
                if (TX_PKT_END) begin
                    st_nxt.pkt_state = usb_dma_state_pkg::PKT_IDLE;
                end
            end
            default: begin
                st_nxt.pkt_state = usb_dma_state_pkg::PKT_IDLE;
            end
        endcase
        if (REG_WR) begin
            case (REG_ADDR)
                `TXSW_OFF_WORD0: begin
                    st_nxt.transmit_queue_front_pointer = REG_WDATA[31:`TXSW_PTR_LSB];
                    st_nxt.pkt_state = REG_WDATA[`TXSW_PKT_BIT] ? usb_dma_state_pkg::PKT_BUSY
                                                                : usb_dma_state_pkg::PKT_IDLE;
                end
                `TXSW_OFF_WORD1: begin
                    st_nxt.packet_first_descriptor_pointer = REG_WDATA[31:`TXSW_PTR_LSB];
                    st_nxt.pkt_state = REG_WDATA[`TXSW_PKT_BIT] ? usb_dma_state_pkg::PKT_BUSY
                                                                : usb_dma_state_pkg::PKT_IDLE;
                end
                default: begin
                end
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                `RXBC_OFF_CH0: st_nxt.rdata = {16'h0000, st_r.queued_buffer_tally[0]};
                `RXBC_OFF_CH1: st_nxt.rdata = {16'h0000, st_r.queued_buffer_tally[1]};
                `RXBC_OFF_CH2: st_nxt.rdata = {16'h0000, st_r.queued_buffer_tally[2]};
                `RXBC_OFF_CH3: st_nxt.rdata = {16'h0000, st_r.queued_buffer_tally[3]};
                `TXSW_OFF_WORD0: st_nxt.rdata = {st_r.transmit_queue_front_pointer, 1'b0, in_pkt};
                `TXSW_OFF_WORD1: st_nxt.rdata = {st_r.packet_first_descriptor_pointer, 1'b0,
                                                 in_pkt};
                `EVQ_OFF_LEVEL:  st_nxt.rdata = {27'h000_0000, evq_level};
                default:         st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (evq_out_valid && evq_out_ready) begin
            st_nxt.evt_valid = 1'b1;
            st_nxt.evt_data  = evq_out_data;
        end
        st_nxt.in_pkt_out = (st_nxt.pkt_state == usb_dma_state_pkg::PKT_BUSY);
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_r <= '0;
            st_r.pkt_state <= usb_dma_state_pkg::PKT_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    usb_dma_event_fifo #(
        .WIDTH (`EVQ_WIDTH),
        .DEPTH (`EVQ_DEPTH)
    ) u_evq (
        .clk       (CLK_SYS),
        .rst       (SYS_RST),
        .in_valid  (evq_in_valid),
        .in_ready  (evq_in_ready),
        .in_data   (evq_in_data),
        .out_valid (evq_out_valid),
        .out_ready (evq_out_ready),
        .out_data  (evq_out_data),
        .level     (evq_level)
    );

    assign REG_RDATA    = st_r.rdata;
    assign RX_BUF_AVAIL = st_r.avail;
    assign TX_IN_PACKET = st_r.in_pkt_out;
    assign EVT_VALID    = st_r.evt_valid;
    assign EVT_DATA     = st_r.evt_data;

    sequence s_add_ch0;
        REG_WR && REG_ADDR == `RXBC_OFF_CH0 && !RX_BUF_CONSUME[0];
    endsequence

    chk_counter_adds : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_add_ch0 |=> st_r.queued_buffer_tally[0] ==
                      $past(st_r.queued_buffer_tally[0]) + $past(REG_WDATA[15:0]))
        else $error("Counter write did not add");

    chk_consume_dec : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        consume_ok[1] && !add_hit[1] |=>
            st_r.queued_buffer_tally[1] == $past(st_r.queued_buffer_tally[1]) - 16'h0001)
        else $error("Consume did not decrement");

    chk_count_upper : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        $past(REG_RD) && $past(REG_ADDR) == `RXBC_OFF_CH2 |-> REG_RDATA[31:16] == 16'h0000)
        else $error("Counter upper half not zero");

    chk_word0_readback : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        REG_WR && REG_ADDR == `TXSW_OFF_WORD0 ##1 REG_RD && REG_ADDR == `TXSW_OFF_WORD0
        |=> REG_RDATA[31:2] == $past(REG_WDATA[31:2], 2))
        else $error("Head pointer readback wrong");

    chk_word1_readback : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        REG_WR && REG_ADDR == `TXSW_OFF_WORD1 && !TX_PKT_START |=>
            st_r.packet_first_descriptor_pointer == $past(REG_WDATA[31:2]))
        else $error("First descriptor write lost");

    chk_reserved_bit : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        $past(REG_RD) && ($past(REG_ADDR) == `TXSW_OFF_WORD0 || $past(REG_ADDR) == `TXSW_OFF_WORD1)
        |-> REG_RDATA[1] == 1'b0 && REG_RDATA[0] == $past(in_pkt))
        else $error("State word low bits wrong");

    chk_pkt_start : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !in_pkt && TX_PKT_START && !REG_WR |=> in_pkt && TX_IN_PACKET)
        else $error("Packet start not flagged");

    chk_avail_three : assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        RX_BUF_AVAIL[0] == (st_r.queued_buffer_tally[0] >= 16'h0003))
        else $error("Availability threshold wrong");

    chk_reset_zero : assert property (@(posedge CLK_SYS)
        $past(SYS_RST) |-> st_r.queued_buffer_tally == '0 && !in_pkt)
        else $error("Reset did not clear state");
endmodule : usb_dma_rx_bufcount_tx_state
`default_nettype wire

// ### pkg/usb_dma_state_map.svh
// Register offsets, field positions, reset values and widths of the
// receive buffer counters and transmit state words.
// Assumes inclusion by bare name from the design files.
`ifndef USB_DMA_STATE_MAP_SVH
`define USB_DMA_STATE_MAP_SVH

`define RXBC_OFF_CH0      8'h00
`define RXBC_OFF_CH1      8'h04
`define RXBC_OFF_CH2      8'h08
`define RXBC_OFF_CH3      8'h0C
`define TXSW_OFF_WORD0    8'h10
`define TXSW_OFF_WORD1    8'h14
`define EVQ_OFF_DATA      8'h18
`define EVQ_OFF_LEVEL     8'h1C
`define RXBC_CNT_MSB      15
`define TXSW_PTR_LSB      2
`define TXSW_PKT_BIT      0
`define RXBC_RESET        16'h0000
`define TXSW_PTR_RESET    30'h0000_0000
`define EVQ_DEPTH         16
`define EVQ_WIDTH         32

`endif

// ### pkg/usb_dma_state_pkg.sv
// Types used by the DMA bookkeeping block; its event FIFO takes plain width parameters.
// Assumes nothing beyond a SystemVerilog compiler.
package usb_dma_state_pkg;
    typedef logic [15:0] tally_t;
    typedef logic [29:0] desc_ptr_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        PKT_IDLE,
        PKT_BUSY
    } pkt_state_t;
endpackage : usb_dma_state_pkg

// ### logic/usb_dma_event_fifo.sv
// Synchronous FIFO with valid/ready handshake on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module usb_dma_event_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    // Fill level
    output logic      [AW:0]      level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign level     = cnt_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overflow : assert property (@(posedge clk) disable iff (rst)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("FIFO level above depth");
endmodule : usb_dma_event_fifo
`default_nettype wire

// ### tb/tb_usb_dma_rx_bufcount_tx_state.sv
// Self-checking bench for the receive buffer counters and transmit state words.
// Assumes the design and its event FIFO are compiled first; offsets come from the map header.
`timescale 1ns/1ps
`default_nettype none
`include "usb_dma_state_map.svh"
module tb_usb_dma_rx_bufcount_tx_state;
    logic        clk_sys;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] reg_rdata;
    logic [3:0]  rx_buf_consume;
    logic        tx_pkt_start;
    logic [29:0] tx_pkt_sop_ptr;
    logic        tx_pkt_end;
    logic [3:0]  rx_buf_avail;
    logic        tx_in_packet;
    logic        evt_valid;
    logic        evt_ready;
    logic [31:0] evt_data;
    logic [31:0] rd_val;
    int          num_errors;
    int          comparisons;
    int          cycles;
    int          n_evt;

    usb_dma_rx_bufcount_tx_state usb_dma_rx_bufcount_tx_state_i (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(wr_stb), .REG_RD(rd_stb), .REG_RDATA(reg_rdata),
        .RX_BUF_CONSUME(rx_buf_consume), .TX_PKT_START(tx_pkt_start),
        .TX_PKT_SOP_PTR(tx_pkt_sop_ptr), .TX_PKT_END(tx_pkt_end),
        .RX_BUF_AVAIL(rx_buf_avail), .TX_IN_PACKET(tx_in_packet),
        .EVT_VALID(evt_valid), .EVT_READY(evt_ready), .EVT_DATA(evt_data)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // A hung run is cut short and counted as a mismatch.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bits(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: flags %b expected %b", $time, got, exp);
        end
    endtask : check_bits

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] cons);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        wr_stb <= 1'b1;
        rx_buf_consume <= cons;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rx_buf_consume <= 4'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        check_word(reg_rdata, exp);
    endtask : reg_rd

    task automatic consume(input logic [3:0] mask, input int n);
        @(posedge clk_sys);
        rx_buf_consume <= mask;
        repeat (n) @(posedge clk_sys);
        rx_buf_consume <= 4'h0;
    endtask : consume

    task automatic tx_pulse(input logic start, input logic [29:0] ptr);
        @(posedge clk_sys);
        tx_pkt_start <= start;
        tx_pkt_end <= ~start;
        tx_pkt_sop_ptr <= ptr;
        @(posedge clk_sys);
        tx_pkt_start <= 1'b0;
        tx_pkt_end <= 1'b0;
    endtask : tx_pulse

    initial begin
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        n_evt = 0;
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, wr_stb, rd_stb, rx_buf_consume} = '0;
        {tx_pkt_start, tx_pkt_sop_ptr, tx_pkt_end, evt_ready} = '0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int k = 0; k < 6; k++) reg_rd(8'(4 * k), 32'h0000_0000);
        reg_rd(`EVQ_OFF_LEVEL, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            reg_wr(8'(4 * k), 32'(k + 1), 4'h0);
            reg_wr(8'(4 * k), 32'hABCD_0002, 4'h0);
            reg_rd(8'(4 * k), 32'(k + 3));
        end
        check_bits(rx_buf_avail, 4'hF);
        reg_wr(`RXBC_OFF_CH0, 32'h0000_0005, 4'h1);
        reg_rd(`RXBC_OFF_CH0, 32'h0000_0007);
        // The stalled event stream lets the FIFO fill and refuse further consumption.
        reg_wr(`RXBC_OFF_CH3, 32'h0000_0064, 4'h0);
        consume(4'h8, 20);
        reg_rd(`RXBC_OFF_CH3, 32'h0000_005A);
        reg_rd(`EVQ_OFF_LEVEL, 32'h0000_0010);
        @(posedge clk_sys);
        evt_ready <= 1'b1;
        repeat (40) begin
            #1;
            if (evt_valid === 1'b1) begin
                if (n_evt == 0) check_word({evt_data[31:16], 16'h0000}, 32'h0000_0000);
                if (n_evt == 1) check_word(evt_data, 32'h0003_006A);
                n_evt++;
            end
            @(posedge clk_sys);
        end
        check_word(32'(n_evt), 32'h0000_0011);
        reg_rd(`EVQ_OFF_LEVEL, 32'h0000_0000);
        reg_wr(`RXBC_OFF_CH2, 32'h0000_FFFB, 4'h0);
        reg_rd(`RXBC_OFF_CH2, 32'h0000_0000);
        consume(4'h4, 1);
        reg_rd(`RXBC_OFF_CH2, 32'h0000_0000);
        check_bits(rx_buf_avail, 4'hB);
        reg_wr(`TXSW_OFF_WORD0, 32'hFFFF_FFFF, 4'h0);
        reg_rd(`TXSW_OFF_WORD0, 32'hFFFF_FFFD);
        reg_rd(`TXSW_OFF_WORD1, 32'h0000_0001);
        check_bits({3'b000, tx_in_packet}, 4'h1);
        reg_wr(`TXSW_OFF_WORD0, 32'h1234_5678, 4'h0);
        reg_rd(`TXSW_OFF_WORD0, 32'h1234_5678);
        tx_pulse(1'b1, 30'h0ABC_DEF1);
        reg_rd(`TXSW_OFF_WORD1, 32'h2AF3_7BC5);
        reg_rd(`TXSW_OFF_WORD0, 32'h1234_5679);
        tx_pulse(1'b0, 30'h0000_0000);
        reg_rd(`TXSW_OFF_WORD1, 32'h2AF3_7BC4);
        check_bits({3'b000, tx_in_packet}, 4'h0);
        reg_wr(`TXSW_OFF_WORD1, 32'h8000_0006, 4'h0);
        reg_rd(`TXSW_OFF_WORD1, 32'h8000_0004);
        reg_wr(8'h20, 32'hFFFF_FFFF, 4'h0);
        reg_rd(`EVQ_OFF_DATA, 32'h0000_0000);
        reg_rd(8'h20, 32'h0000_0000);
        reg_rd(`RXBC_OFF_CH1, 32'h0000_0004);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        reg_rd(`RXBC_OFF_CH0, 32'h0000_0000);
        reg_rd(`TXSW_OFF_WORD1, 32'h0000_0000);
        check_bits(rx_buf_avail, 4'h0);
        final_report();
    end
endmodule : tb_usb_dma_rx_bufcount_tx_state
`default_nettype wire
